// File: rtl/fos_pkg.sv
// Constants, command codes and types for the one-time region and protection command unit
// Overview of operation
// - Erase suspend accepts protect read, quad programs
// - Either suspend accepts every array read opcode
// - Both status reads accepted in either suspend
// - Write enable accepted only in erase suspend
// - Suspended register write needs preceding bank access
// - Region program needs write enable latch set
// - Region program uses page program bus sequence
// - Zeros into locked region fail, set error
// - Programming ones never raises the error bit
// - Region bits only go from one to zero
// - Region read never wraps; beyond top undefined
// - Region read always has one dummy byte
// - Protect read shifts low byte first, falling
// - Protect read repeats every sixteen clocks
// - Protect program needs write enable latch set
// - Select must rise after bit sixteen exactly
// - Self-timed protect program holds busy flag
// - Protect program updates flags like programming
// - Completion clears the write enable latch
// - Program into suspended erase sector fails
// - Erase resume only acts while erase suspended
package fos_pkg;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] REGISTER_WRITE_CMD = 8'h01;
  localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] NORMAL_READ_CMD = 8'h03;
  localparam logic [7:0] STATUS_ONE_READ_CMD = 8'h05;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] STATUS_TWO_READ_CMD = 8'h07;
  localparam logic [7:0] FAST_READ_CMD = 8'h0b;
  localparam logic [7:0] FAST_READ_4BYTE_CMD = 8'h0c;
  localparam logic [7:0] PAGE_PROGRAM_4BYTE_CMD = 8'h12;
  localparam logic [7:0] NORMAL_READ_4BYTE_CMD = 8'h13;
  localparam logic [7:0] BANK_READ_CMD = 8'h16;
  localparam logic [7:0] BANK_WRITE_CMD = 8'h17;
  localparam logic [7:0] SECTOR_PROTECT_REG_READ_CMD = 8'h2b;
  localparam logic [7:0] SECTOR_PROTECT_REG_PROGRAM_CMD = 8'h2f;
  localparam logic [7:0] CLEAR_STATUS_CMD = 8'h30;
  localparam logic [7:0] QUAD_INPUT_PAGE_PROGRAM_CMD = 8'h32;
  localparam logic [7:0] QUAD_INPUT_PAGE_PROGRAM_4BYTE_CMD = 8'h34;
  localparam logic [7:0] CONFIG_REG_READ_CMD = 8'h35;
  localparam logic [7:0] QUAD_INPUT_PAGE_PROGRAM_ALT_CMD = 8'h38;
  localparam logic [7:0] ONE_TIME_REGION_PROGRAM_CMD = 8'h42;
  localparam logic [7:0] ONE_TIME_REGION_READ_CMD = 8'h4b;
  localparam logic [7:0] QUAD_OUTPUT_READ_CMD = 8'h6b;
  localparam logic [7:0] QUAD_OUTPUT_READ_4BYTE_CMD = 8'h6c;
  localparam logic [7:0] ERASE_RESUME_CMD = 8'h7a;
  localparam logic [7:0] PROGRAM_SUSPEND_CMD = 8'h85;
  localparam logic [7:0] PROGRAM_RESUME_CMD = 8'h8a;
  localparam logic [7:0] BANK_ADDRESS_ACCESS_CMD = 8'hb9;
  localparam logic [7:0] DYN_PROTECT_READ_CMD = 8'he0;
  localparam logic [7:0] DYN_PROTECT_WRITE_CMD = 8'he1;
  localparam logic [7:0] PERSISTENT_PROTECT_READ_CMD = 8'he2;
  localparam logic [7:0] QUAD_IO_READ_CMD = 8'heb;
  localparam logic [7:0] QUAD_IO_READ_4BYTE_CMD = 8'hec;
  localparam logic [7:0] DOUBLE_RATE_QUAD_IO_READ_CMD = 8'hed;
  localparam logic [7:0] DOUBLE_RATE_QUAD_IO_READ_4BYTE_CMD = 8'hee;
  localparam logic [7:0] SOFT_RESET_CMD = 8'hf0;
  localparam logic [7:0] MODE_BIT_RESET_CMD = 8'hff;

  // ************************************************************
  // Sizes, positions, reset values, timing
  // ************************************************************
  localparam logic [31:0] OTP_BYTES = 32'h0000_0800;
  localparam int OTP_AW = 11;
  localparam int OTP_REGION_SHIFT = 7;
  localparam int OTP_REGIONS = 16;
  localparam int PAGE_BYTES = 16;
  localparam int SECTOR_SHIFT = 18;
  localparam int SECTOR_W = 14;
  localparam logic [2:0] ADDR_LEN_3 = 3'h3;
  localparam logic [2:0] ADDR_LEN_4 = 3'h4;
  localparam logic [4:0] ASP_DATA_BYTES = 5'h02;
  localparam logic [7:0] OTP_ERASED = 8'hff;
  localparam logic [7:0] UNDEF_BYTE = 8'hff;
  localparam logic [15:0] ASP_RESET = 16'hffff;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam int SR1_WIP_BIT = 0;
  localparam int SR1_WEL_BIT = 1;
  localparam int SR1_PERR_BIT = 6;
  localparam int SR2_PS_BIT = 0;
  localparam int SR2_ES_BIT = 1;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 2000;
  localparam logic [15:0] PROG_CYCLES =
    16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA_IN, ST_DATA_OUT, ST_SKIP
  } fos_state_t;

  typedef enum logic [1:0] {SRC_SR1, SRC_SR2, SRC_ASP, SRC_OTP} fos_src_t;

  typedef struct packed {
    logic erase_suspended;
    logic program_suspended;
    logic erase_done;
    logic program_resumed;
  } fos_core_evt_t;

  typedef struct packed {
    logic p_err;
    logic write_enable_latch;
    logic write_in_progress;
    logic erase_susp;
    logic prog_susp;
  } fos_status_t;

endpackage : fos_pkg

// File: rtl/fos_pin_sync.sv
// Three-stage pin sampler with agreement filter and edge pulses
`timescale 1ns/1ps
module fos_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic lvl,
  output logic rise,
  output logic fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // A change counts only once the last two stages agree
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;
  end

  assign lvl = lvl_q;
  assign rise = lvl_d & ~lvl_q;
  assign fall = ~lvl_d & lvl_q;

endmodule : fos_pin_sync

// File: rtl/fos_cmd_unit.sv
// Serial command unit: suspend filtering, one-time region and protection register
`timescale 1ns/1ps
module fos_cmd_unit (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire fos_pkg::fos_core_evt_t core_evt,
  input wire logic [fos_pkg::OTP_REGIONS-1:0] otp_lock,
  input wire logic [fos_pkg::SECTOR_W-1:0] susp_sector,
  output fos_pkg::fos_status_t status,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [7:0] bank_reg,
  output logic [15:0] asp_reg
);

  // ************************************************************
  // Pin sampling
  // ************************************************************
  logic sck_rise;
  logic sck_fall;
  logic cs_lvl;
  logic cs_rise;
  logic si_lvl;

  fos_pin_sync #(.RST_VAL(1'b0)) u_sck (
    .clk(clk), .nrst(nrst), .pin(sck), .lvl(), .rise(sck_rise), .fall(sck_fall)
  );
  fos_pin_sync #(.RST_VAL(1'b1)) u_cs (
    .clk(clk), .nrst(nrst), .pin(cs_n), .lvl(cs_lvl), .rise(cs_rise), .fall()
  );
  fos_pin_sync #(.RST_VAL(1'b0)) u_si (
    .clk(clk), .nrst(nrst), .pin(si), .lvl(si_lvl), .rise(), .fall()
  );

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic is_array_prog(input logic [7:0] op);
    return (op == fos_pkg::PAGE_PROGRAM_CMD) || (op == fos_pkg::PAGE_PROGRAM_4BYTE_CMD) ||
           (op == fos_pkg::QUAD_INPUT_PAGE_PROGRAM_CMD) ||
           (op == fos_pkg::QUAD_INPUT_PAGE_PROGRAM_ALT_CMD) ||
           (op == fos_pkg::QUAD_INPUT_PAGE_PROGRAM_4BYTE_CMD);
  endfunction : is_array_prog

  // Which opcodes pass in each suspend state; busy allows only status reads
  function automatic logic op_allowed(input logic [7:0] op, input logic es,
                                      input logic ps, input logic bank_address_access_cmd, input logic busy);
    logic ok;
    ok = 1'b0;
    if (busy) begin
      ok = (op == fos_pkg::STATUS_ONE_READ_CMD) || (op == fos_pkg::STATUS_TWO_READ_CMD);
    end else if (!es && !ps) begin
      ok = 1'b1;
    end else begin
      unique case (op)
        fos_pkg::NORMAL_READ_CMD, fos_pkg::NORMAL_READ_4BYTE_CMD,
        fos_pkg::FAST_READ_CMD, fos_pkg::FAST_READ_4BYTE_CMD,
        fos_pkg::QUAD_OUTPUT_READ_CMD, fos_pkg::QUAD_OUTPUT_READ_4BYTE_CMD,
        fos_pkg::QUAD_IO_READ_CMD, fos_pkg::QUAD_IO_READ_4BYTE_CMD,
        fos_pkg::DOUBLE_RATE_QUAD_IO_READ_CMD,
        fos_pkg::DOUBLE_RATE_QUAD_IO_READ_4BYTE_CMD: ok = 1'b1;
        fos_pkg::STATUS_ONE_READ_CMD, fos_pkg::STATUS_TWO_READ_CMD: ok = 1'b1;
        fos_pkg::CONFIG_REG_READ_CMD, fos_pkg::BANK_ADDRESS_ACCESS_CMD,
        fos_pkg::BANK_READ_CMD, fos_pkg::BANK_WRITE_CMD, fos_pkg::MODE_BIT_RESET_CMD,
        fos_pkg::PROGRAM_RESUME_CMD, fos_pkg::SOFT_RESET_CMD: ok = 1'b1;
        fos_pkg::REGISTER_WRITE_CMD: ok = bank_address_access_cmd;
        fos_pkg::PERSISTENT_PROTECT_READ_CMD, fos_pkg::QUAD_INPUT_PAGE_PROGRAM_CMD,
        fos_pkg::QUAD_INPUT_PAGE_PROGRAM_ALT_CMD,
        fos_pkg::QUAD_INPUT_PAGE_PROGRAM_4BYTE_CMD: ok = es;
        fos_pkg::WRITE_ENABLE_CMD: ok = es;
        fos_pkg::ERASE_RESUME_CMD, fos_pkg::CLEAR_STATUS_CMD,
        fos_pkg::DYN_PROTECT_READ_CMD, fos_pkg::DYN_PROTECT_WRITE_CMD,
        fos_pkg::PROGRAM_SUSPEND_CMD, fos_pkg::PAGE_PROGRAM_CMD,
        fos_pkg::PAGE_PROGRAM_4BYTE_CMD: ok = es;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction : op_allowed

  // ************************************************************
  // State
  // ************************************************************
  fos_pkg::fos_state_t state_q;
  fos_pkg::fos_src_t src_q;
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic [2:0] cnt_q;
  logic [2:0] alen_q;
  logic [7:0] opc_q;
  logic [31:0] addr_q;
  logic [4:0] nbytes_q;
  logic [7:0] pbuf_q [fos_pkg::PAGE_BYTES];
  logic [15:0] ocnt_q;
  logic so_q;
  logic so_oe_q;
  logic [7:0] otp_q [2048];
  logic wel_q;
  logic busy_q;
  logic [15:0] tmr_q;
  logic p_err_q;
  logic es_q;
  logic ps_q;
  logic erun_q;
  logic wip_q;
  logic bank_address_access_cmd_q;
  logic [15:0] asp_q;
  logic [7:0] bank_q;
  logic cmd_valid_q;
  logic [7:0] cmd_code_q;

  logic [7:0] rx_byte;
  logic opc_done;
  logic accept;
  fos_pkg::fos_state_t dec_state;
  fos_pkg::fos_src_t dec_src;
  logic [2:0] dec_alen;
  logic frame_in;
  logic asp_go;
  logic otp_go;
  logic bank_go;
  logic prog_fail;
  logic otp_fail;
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [31:0] rd_addr;
  logic [7:0] tx_byte;
  logic tx_bit;

  assign rx_byte = {sh_q, si_lvl};
  assign opc_done = sck_rise && !cs_lvl && (bit_q == 3'h7) && (state_q == fos_pkg::ST_OPCODE);
  assign accept = op_allowed(rx_byte, es_q, ps_q, bank_address_access_cmd_q, busy_q);

  // ************************************************************
  // Opcode decode
  // ************************************************************
  always_comb begin
    dec_state = fos_pkg::ST_SKIP;
    dec_src = fos_pkg::SRC_SR1;
    dec_alen = fos_pkg::ADDR_LEN_3;
    if (accept) begin
      unique case (rx_byte)
        fos_pkg::STATUS_ONE_READ_CMD: dec_state = fos_pkg::ST_DATA_OUT;
        fos_pkg::STATUS_TWO_READ_CMD: begin
          dec_state = fos_pkg::ST_DATA_OUT;
          dec_src = fos_pkg::SRC_SR2;
        end
        fos_pkg::SECTOR_PROTECT_REG_READ_CMD: begin
          dec_state = fos_pkg::ST_DATA_OUT;
          dec_src = fos_pkg::SRC_ASP;
        end
        fos_pkg::ONE_TIME_REGION_READ_CMD: begin
          dec_state = fos_pkg::ST_ADDR;
          dec_src = fos_pkg::SRC_OTP;
        end
        fos_pkg::ONE_TIME_REGION_PROGRAM_CMD: begin
          dec_state = wel_q ? fos_pkg::ST_ADDR : fos_pkg::ST_SKIP;
        end
        fos_pkg::SECTOR_PROTECT_REG_PROGRAM_CMD: begin
          dec_state = wel_q ? fos_pkg::ST_DATA_IN : fos_pkg::ST_SKIP;
        end
        fos_pkg::REGISTER_WRITE_CMD: begin
          dec_state = (es_q || ps_q) ? fos_pkg::ST_DATA_IN : fos_pkg::ST_SKIP;
        end
        fos_pkg::PAGE_PROGRAM_4BYTE_CMD, fos_pkg::QUAD_INPUT_PAGE_PROGRAM_4BYTE_CMD: begin
          dec_state = fos_pkg::ST_ADDR;
          dec_alen = fos_pkg::ADDR_LEN_4;
        end
        fos_pkg::PAGE_PROGRAM_CMD, fos_pkg::QUAD_INPUT_PAGE_PROGRAM_CMD,
        fos_pkg::QUAD_INPUT_PAGE_PROGRAM_ALT_CMD: dec_state = fos_pkg::ST_ADDR;
        default: dec_state = fos_pkg::ST_SKIP;
      endcase
    end
  end

  // ************************************************************
  // Input shifter and frame sequencer
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= fos_pkg::ST_OPCODE;
      src_q <= fos_pkg::SRC_SR1;
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      cnt_q <= 3'h0;
      alen_q <= fos_pkg::ADDR_LEN_3;
      opc_q <= 8'h00;
      addr_q <= 32'h0000_0000;
      nbytes_q <= 5'h00;
      for (int i = 0; i < fos_pkg::PAGE_BYTES; i++) begin
        pbuf_q[i] <= fos_pkg::OTP_ERASED;
      end
    end else if (cs_lvl) begin
      state_q <= fos_pkg::ST_OPCODE;
      bit_q <= 3'h0;
      cnt_q <= 3'h0;
      nbytes_q <= 5'h00;
    end else if (sck_rise) begin
      sh_q <= rx_byte[6:0];
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        unique case (state_q)
          fos_pkg::ST_OPCODE: begin
            opc_q <= rx_byte;
            state_q <= dec_state;
            src_q <= dec_src;
            alen_q <= dec_alen;
            cnt_q <= 3'h0;
            addr_q <= 32'h0000_0000;
          end
          fos_pkg::ST_ADDR: begin
            addr_q <= {addr_q[23:0], rx_byte};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == alen_q - 3'h1) begin
              state_q <= (opc_q == fos_pkg::ONE_TIME_REGION_READ_CMD) ?
                         fos_pkg::ST_DUMMY : fos_pkg::ST_DATA_IN;
            end
          end
          fos_pkg::ST_DUMMY: state_q <= fos_pkg::ST_DATA_OUT;
          fos_pkg::ST_DATA_IN: begin
            pbuf_q[nbytes_q[3:0]] <= rx_byte;
            if (nbytes_q != 5'h1f) begin
              nbytes_q <= nbytes_q + 5'h01;
            end
          end
          fos_pkg::ST_DATA_OUT, fos_pkg::ST_SKIP: state_q <= state_q;
        endcase
      end
    end
  end

  // ************************************************************
  // Frame end actions
  // ************************************************************
  assign frame_in = cs_rise && (state_q == fos_pkg::ST_DATA_IN) && (bit_q == 3'h0);
  assign asp_go = frame_in && (opc_q == fos_pkg::SECTOR_PROTECT_REG_PROGRAM_CMD) &&
                  (nbytes_q == fos_pkg::ASP_DATA_BYTES) && wel_q;
  assign otp_go = frame_in && (opc_q == fos_pkg::ONE_TIME_REGION_PROGRAM_CMD) &&
                  (nbytes_q != 5'h00) && wel_q;
  assign bank_go = frame_in && (opc_q == fos_pkg::REGISTER_WRITE_CMD) && (nbytes_q != 5'h00);
  assign prog_fail = cs_rise && (state_q == fos_pkg::ST_DATA_IN) && is_array_prog(opc_q) &&
                     es_q && (addr_q[31:fos_pkg::SECTOR_SHIFT] == susp_sector);

  // Zeros aimed at a locked region fail; an all-ones byte never does
  always_comb begin
    logic [fos_pkg::OTP_AW-1:0] a;
    a = '0;
    otp_fail = 1'b0;
    for (int i = 0; i < fos_pkg::PAGE_BYTES; i++) begin
      a = addr_q[fos_pkg::OTP_AW-1:0] + fos_pkg::OTP_AW'(i);
      if ((5'(i) < nbytes_q) && otp_lock[a[fos_pkg::OTP_AW-1:fos_pkg::OTP_REGION_SHIFT]] &&
          (pbuf_q[i] != fos_pkg::OTP_ERASED)) begin
        otp_fail = 1'b1;
      end
    end
  end

  // ************************************************************
  // One-time region array
  // ************************************************************
  // Whole page commits at select rise; only ones can be cleared
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int j = 0; j < 2048; j++) begin
        otp_q[j] <= fos_pkg::OTP_ERASED;
      end
    end else if (otp_go && !otp_fail) begin
      for (int i = 0; i < fos_pkg::PAGE_BYTES; i++) begin
        if (5'(i) < nbytes_q) begin
          otp_q[addr_q[fos_pkg::OTP_AW-1:0] + fos_pkg::OTP_AW'(i)] <=
            otp_q[addr_q[fos_pkg::OTP_AW-1:0] + fos_pkg::OTP_AW'(i)] & pbuf_q[i];
        end
      end
    end
  end

  // ************************************************************
  // Status flags and self-timed operations
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      tmr_q <= 16'h0000;
      p_err_q <= 1'b0;
      es_q <= 1'b0;
      ps_q <= 1'b0;
      erun_q <= 1'b0;
      wip_q <= 1'b0;
      bank_address_access_cmd_q <= 1'b0;
      asp_q <= fos_pkg::ASP_RESET;
      bank_q <= fos_pkg::BANK_RESET;
    end else begin
      if (opc_done && accept && (rx_byte == fos_pkg::WRITE_ENABLE_CMD)) begin
        wel_q <= 1'b1;
      end
      if (opc_done) begin
        bank_address_access_cmd_q <= accept && (rx_byte == fos_pkg::BANK_ADDRESS_ACCESS_CMD);
      end
      if (busy_q) begin
        tmr_q <= tmr_q - 16'h0001;
        if (tmr_q == 16'h0001) begin
          busy_q <= 1'b0;
          wel_q <= 1'b0;
        end
      end
      if (asp_go || otp_go) begin
        busy_q <= 1'b1;
        tmr_q <= fos_pkg::PROG_CYCLES;
      end
      if (asp_go) begin
        asp_q <= asp_q & {pbuf_q[1], pbuf_q[0]};
      end
      if ((otp_go && otp_fail) || prog_fail) begin
        p_err_q <= 1'b1;
      end
      if (bank_go) begin
        bank_q <= pbuf_q[0];
      end
      if (opc_done && accept && es_q && (rx_byte == fos_pkg::ERASE_RESUME_CMD)) begin
        es_q <= 1'b0;
        erun_q <= 1'b1;
      end
      if (core_evt.erase_done) begin
        erun_q <= 1'b0;
      end
      // A suspend report in the resume cycle wins
      if (core_evt.erase_suspended) begin
        es_q <= 1'b1;
        erun_q <= 1'b0;
      end
      if (core_evt.program_resumed) begin
        ps_q <= 1'b0;
      end
      if (core_evt.program_suspended) begin
        ps_q <= 1'b1;
      end
      wip_q <= busy_q || erun_q;
    end
  end

  // ************************************************************
  // Forwarding of accepted opcodes to the array core
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_valid_q <= 1'b0;
      cmd_code_q <= 8'h00;
    end else begin
      cmd_valid_q <= opc_done && accept;
      if (opc_done && accept) begin
        cmd_code_q <= rx_byte;
      end
    end
  end

  // ************************************************************
  // Output shifter
  // ************************************************************
  always_comb begin
    sr1 = 8'h00;
    sr1[fos_pkg::SR1_WIP_BIT] = wip_q;
    sr1[fos_pkg::SR1_WEL_BIT] = wel_q;
    sr1[fos_pkg::SR1_PERR_BIT] = p_err_q;
    sr2 = 8'h00;
    sr2[fos_pkg::SR2_PS_BIT] = ps_q;
    sr2[fos_pkg::SR2_ES_BIT] = es_q;
    rd_addr = addr_q + {19'h00000, ocnt_q[15:3]};
    unique case (src_q)
      fos_pkg::SRC_SR1: tx_byte = sr1;
      fos_pkg::SRC_SR2: tx_byte = sr2;
      fos_pkg::SRC_ASP: tx_byte = ocnt_q[3] ? asp_q[15:8] : asp_q[7:0];
      fos_pkg::SRC_OTP: tx_byte = (rd_addr < fos_pkg::OTP_BYTES) ?
                                  otp_q[rd_addr[fos_pkg::OTP_AW-1:0]] :
                                  fos_pkg::UNDEF_BYTE;
    endcase
    tx_bit = tx_byte[3'h7 - ocnt_q[2:0]];
  end

  // Output changes only on falling clock edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      ocnt_q <= 16'h0000;
    end else if (cs_lvl) begin
      so_oe_q <= 1'b0;
      ocnt_q <= 16'h0000;
    end else if (sck_fall && (state_q == fos_pkg::ST_DATA_OUT)) begin
      so_q <= tx_bit;
      so_oe_q <= 1'b1;
      ocnt_q <= ocnt_q + 16'h0001;
    end
  end

  assign so = so_q;
  assign so_oe = so_oe_q;
  assign status = '{p_err: p_err_q, write_enable_latch: wel_q, write_in_progress: wip_q, erase_susp: es_q, prog_susp: ps_q};
  assign cmd_valid = cmd_valid_q;
  assign cmd_code = cmd_code_q;
  assign bank_reg = bank_q;
  assign asp_reg = asp_q;

endmodule : fos_cmd_unit

// File: bench/fos_cmd_unit_props.sv
// Port checks for the serial command unit
`timescale 1ns/1ps
module fos_cmd_unit_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire fos_pkg::fos_core_evt_t core_evt,
  input wire logic [15:0] otp_lock,
  input wire logic [13:0] susp_sector,
  input wire fos_pkg::fos_status_t status,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] bank_reg,
  input wire logic [15:0] asp_reg
);
  // *****
  // Checks
  // *****
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  asp_guard_a: assert property ($changed(asp_reg) |-> cs_n && status.write_enable_latch)
    else $error("asp write unguarded");
  asp_mono_a: assert property ((asp_reg & ~$past(asp_reg)) == 16'h0)
    else $error("asp bit went high");
  asp_done_a: assert property (
    $changed(asp_reg) |-> ##190 status.write_in_progress ##[1:15] !status.write_in_progress && !status.write_enable_latch)
    else $error("asp busy span wrong");
  wip_wel_a: assert property (
    $rose(status.write_in_progress) && !$past(status.erase_susp, 2) |-> $past(status.write_enable_latch))
    else $error("program without latch");
  prog_susp_a: assert property (
    cmd_valid && status.prog_susp && !status.erase_susp |->
    cmd_code inside {8'hb9, 8'h16, 8'h17, 8'h0b, 8'h0c, 8'hff, 8'h8a, 8'h13, 8'h35,
    8'hed, 8'hee, 8'heb, 8'hec, 8'h6b, 8'h6c, 8'h05, 8'h07, 8'h03, 8'hf0, 8'h01})
    else $error("opcode taken in program suspend");
  bank_susp_a: assert property (
    $changed(bank_reg) |-> status.erase_susp || status.prog_susp)
    else $error("bank written outside suspend");
  so_edge_a: assert property ($changed(so) |-> !sck)
    else $error("so moved with clock high");
  oe_release_a: assert property (cs_n [*7] |-> !so_oe)
    else $error("so driven while deselected");
endmodule : fos_cmd_unit_props

bind fos_cmd_unit fos_cmd_unit_props i_props (.clk, .nrst, .sck, .cs_n, .si, .so, .so_oe,
  .core_evt, .otp_lock, .susp_sector, .status, .cmd_valid, .cmd_code, .bank_reg, .asp_reg);

// File: bench/fos_host.sv
// Host serial controller model
`timescale 1ns/1ps
module fos_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Clock at 8 MHz, far below 133 MHz, still between frames
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      si = tx[n-1-i];
      #62.5 sck = 1'b1;
      #62.5 rx = {rx[62:0], so};
      sck = 1'b0;
    end
    #100 cs_n = 1'b1;
    si = ~si;
    #100;
  endtask : frame
endmodule : fos_host

// File: bench/test_fos_cmd_unit.sv
// Self-checking bench for the serial command unit
`timescale 1ns/1ps
module test_fos_cmd_unit;
  logic clk, nrst, sck, cs_n, si, so, so_oe, cmd_valid;
  fos_pkg::fos_core_evt_t core_evt;
  fos_pkg::fos_status_t status;
  logic [15:0] otp_lock, asp_reg;
  logic [13:0] susp_sector;
  logic [7:0] cmd_code, bank_reg;
  logic [63:0] rx;
  int num_errors = 0, checked = 0, n_ok = 0;
  fos_host i_host (.sck, .cs_n, .si, .so);
  fos_cmd_unit i_dut (.clk, .nrst, .sck, .cs_n, .si, .so, .so_oe, .core_evt, .otp_lock,
    .susp_sector, .status, .cmd_valid, .cmd_code, .bank_reg, .asp_reg);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (cmd_valid === 1'b1) n_ok++;
  // *****
  // Tasks
  // *****
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic tx(input logic [63:0] d, input int n);
    i_host.frame(d, n, rx);
    @(posedge clk);
    #1;
  endtask : tx
  task automatic pulse(input fos_pkg::fos_core_evt_t e);
    @(posedge clk);
    #1 core_evt = e;
    @(posedge clk);
    #1 core_evt = '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse
  task automatic sc_asp;
    tx(64'h2f_a53c, 24);
    chk(asp_reg, 16'hffff);
    tx(64'h06, 8);
    tx(64'h17d29e, 23);
    chk(asp_reg, 16'hffff);
    tx(64'h2f_a53c, 24);
    chk(status.write_in_progress, 1'b1);
    repeat (300) @(posedge clk);
    chk({status.write_in_progress, status.write_enable_latch, status.p_err}, 3'h0);
    chk(asp_reg, 16'h3ca5);
    tx(64'h2b_0000_0000, 40);
    chk(rx[31:0], 32'ha53c_a53c);
  endtask : sc_asp
  task automatic sc_susp;
    int n;
    pulse(4'h4);
    tx(64'h06, 8);
    chk(status.write_enable_latch, 1'b0);
    tx(64'h07_00, 16);
    chk(rx[1:0], 2'h1);
    n = n_ok;
    tx(64'h03_000000, 32);
    chk(n_ok, n + 1);
    chk(cmd_code, 8'h03);
    pulse(4'h1);
    pulse(4'h8);
    tx(64'h01_5a, 16);
    chk(bank_reg, 8'h00);
    tx(64'hb9, 8);
    tx(64'h01_5a, 16);
    chk(bank_reg, 8'h5a);
    tx(64'h06, 8);
    chk(status.write_enable_latch, 1'b1);
    tx(64'h7a, 8);
    chk({status.write_in_progress, status.erase_susp}, 2'h2);
    pulse(4'h2);
    chk(status.write_in_progress, 1'b0);
  endtask : sc_susp
  task automatic sc_otp;
    tx(64'h06, 8);
    tx(64'h42_000000_00, 40);
    repeat (300) @(posedge clk);
    tx(64'h4b_000000_00_0000, 56);
    chk(rx[15:0], 16'h00ff);
    tx(64'h4b_0007ff_00_0000, 56);
    chk(rx[15:0], {fos_pkg::OTP_ERASED, fos_pkg::UNDEF_BYTE});
    otp_lock = 16'h0001;
    tx(64'h06, 8);
    tx(64'h42_000001_ff, 40);
    repeat (300) @(posedge clk);
    chk(status.p_err, 1'b0);
    tx(64'h06, 8);
    tx(64'h42_000001_0f, 40);
    repeat (300) @(posedge clk);
    chk(status.p_err, 1'b1);
    tx(64'h4b_000001_00_00, 48);
    chk(rx[7:0], 8'hff);
  endtask : sc_otp
  // Error flag is sticky, so a mid-run reset clears it before the sector checks
  task automatic sc_sect;
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    chk({status, bank_reg, asp_reg}, 29'h0000ffff);
    pulse(4'h8);
    susp_sector = 14'h0001;
    tx(64'h06, 8);
    tx(64'h02_000000_00, 40);
    chk(status.p_err, 1'b0);
    susp_sector = 14'h0000;
    tx(64'h02_000000_00, 40);
    chk(status.p_err, 1'b1);
  endtask : sc_sect
  initial begin
    nrst = 1'b0;
    core_evt = '0;
    otp_lock = '0;
    susp_sector = '0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    chk({status, bank_reg, asp_reg}, 29'h0000ffff);
    sc_asp();
    sc_susp();
    sc_otp();
    sc_sect();
    give_verdict();
  end
  initial begin
    #1000000;
    num_errors++;
    give_verdict();
  end
endmodule : test_fos_cmd_unit
